// File: rtl/evlrx_core.sv
// Event latches with snapshot read protocol and received word readout.
// Assumes one-cycle event pulses and one-cycle read strobes from the
// serial interface; rd_addr is valid with rd_strobe.
//
// Behaviour
// - Primary bits 0-3: rx, tx, arb, done
// - Primary bits 4-6: busy, timer, sat change
// - Latch events regardless of enables
// - Primary readable anytime
// - Primary read: irq off, snapshot, clear
// - Primary read returns snapshot
// - New events latched; irq held inactive
// - Secondary read returns snapshot
// - Reassert irq after secondary if pending
// - Secondary bits 0-3: data, dot, sync
// - Secondary bits 4-7: idle, tally, gpio, afc
// - No priority among event flags
// - High byte holds word bits 27-20
// - Upper mid byte holds bits 19-12
// - Lower mid byte holds bits 11-4
// - Low register: bits 0-3 high, status low
// - Decode status codes for parity/data errors
// - Codes for erasures and uncorrected
// - Erasure means equal nonzero ones and zeros
// - Port registers show live terminal state
`timescale 1ns/100ps
`include "evlrx_regs.svh"
module evlrx_core #(
    parameter int PORT_C_W = `EVLRX_PORT_C_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register read port
    input wire logic rd_strobe,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // Primary event sources
    input wire logic ev_rx_avail,
    input wire logic ev_tx_buf_avail,
    input wire logic ev_arb_fail,
    input wire logic ev_tx_done,
    input wire logic ev_busy_change,
    input wire logic ev_timer_zero,
    input wire logic ev_sat_change,
    // Secondary event sources
    input wire logic ev_data_change,
    input wire logic ev_dotting,
    input wire logic ev_fvc_sync,
    input wire logic ev_focc_sync,
    input wire logic ev_idle_ps,
    input wire logic ev_narrowband_error_tally,
    input wire logic ev_gpio_group_three,
    input wire logic ev_afc_term,
    // Interrupt enables held elsewhere
    input wire logic [`EVLRX_PRI_W-1:0] ie_primary,
    input wire logic [`EVLRX_SEC_W-1:0] ie_secondary,
    // Received word repeats and decode summary
    input wire logic rep_clear,
    input wire logic rep_valid,
    input wire logic [`EVLRX_WORD_W-1:0] rep_bits,
    input wire logic word_load,
    input wire logic [1:0] parity_errs,
    input wire logic [1:0] data_fixes,
    input wire logic uncorrectable,
    // Terminal groups
    input wire logic [7:0] port_a_pins,
    input wire logic [7:0] port_b_pins,
    input wire logic [PORT_C_W-1:0] port_c_pins,
    // Interrupt
    output logic irq_out
);
    // Port C is padded into one byte, so it cannot exceed eight bits
    if (PORT_C_W < 1 || PORT_C_W > 8) begin : g_bad_width
        $error("evlrx_core: PORT_C_W out of range");
    end

    logic [`EVLRX_WORD_W-1:0] voted, erased;
    evlrx_vote #(.WIDTH(`EVLRX_WORD_W), .CW(4)) u_vote (
        .clk(clk),
        .rst_n(rst_n),
        .clear(rep_clear),
        .rep_valid(rep_valid),
        .rep_bits(rep_bits),
        .voted(voted),
        .erased(erased)
    );

    // Raw event vectors; no ordering among them
    logic [`EVLRX_PRI_W-1:0] pri_ev;
    logic [`EVLRX_SEC_W-1:0] sec_ev;
    assign pri_ev = {ev_sat_change, ev_timer_zero, ev_busy_change,
                     ev_tx_done, ev_arb_fail, ev_tx_buf_avail,
                     ev_rx_avail};
    assign sec_ev = {ev_afc_term, ev_gpio_group_three,
                     ev_narrowband_error_tally, ev_idle_ps, ev_focc_sync,
                     ev_fvc_sync, ev_dotting, ev_data_change};

    logic rd_pri, rd_sec;
    assign rd_pri = rd_strobe && (rd_addr == `EVLRX_ADDR_EV_PRI);
    assign rd_sec = rd_strobe && (rd_addr == `EVLRX_ADDR_EV_SEC);

    // Event and protocol state
    logic [`EVLRX_PRI_W-1:0] pri_q, pri_d, pri_buf_q, pri_buf_d;
    logic [`EVLRX_SEC_W-1:0] sec_q, sec_d, sec_buf_q, sec_buf_d;
    evlrx_pkg::evlrx_seq_t seq_q, seq_d;
    logic irq_q, irq_d;

    always_comb begin
        pri_d = pri_q;
        sec_d = sec_q;
        pri_buf_d = pri_buf_q;
        sec_buf_d = sec_buf_q;
        seq_d = seq_q;
        if (rd_pri) begin
            // Snapshot both, clear live; same-cycle events survive
            pri_buf_d = pri_q | pri_ev;
            sec_buf_d = sec_q | sec_ev;
            pri_d = '0;
            sec_d = '0;
            seq_d = evlrx_pkg::EVLRX_PRI_DONE;
        end else begin
            // Latch independent of enables
            pri_d = pri_q | pri_ev;
            sec_d = sec_q | sec_ev;
            case (seq_q)
                evlrx_pkg::EVLRX_IDLE: begin
                    seq_d = evlrx_pkg::EVLRX_IDLE;
                end
                evlrx_pkg::EVLRX_PRI_DONE: begin
                    // Secondary read closes the sequence
                    if (rd_sec) begin
                        seq_d = evlrx_pkg::EVLRX_IDLE;
                    end
                end
                default: begin
                    seq_d = evlrx_pkg::EVLRX_IDLE;
                end
            endcase
        end
        // Held low through the sequence, enabled flags otherwise
        irq_d = (seq_d == evlrx_pkg::EVLRX_IDLE) &&
                (|(pri_d & ie_primary) || |(sec_d & ie_secondary));
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pri_q <= '0;
            sec_q <= '0;
            pri_buf_q <= '0;
            sec_buf_q <= '0;
            seq_q <= evlrx_pkg::EVLRX_IDLE;
            irq_q <= 1'b0;
        end else begin
            pri_q <= pri_d;
            sec_q <= sec_d;
            pri_buf_q <= pri_buf_d;
            sec_buf_q <= sec_buf_d;
            seq_q <= seq_d;
            irq_q <= irq_d;
        end
    end
    assign irq_out = irq_q;

    // Decode status from decoder summary and erasure count
    function automatic logic [3:0] evlrx_status(
        input logic [1:0] par,
        input logic [1:0] fix,
        input logic fail,
        input logic many_er
    );
        logic [3:0] s;
        s = `EVLRX_DS_NONE;
        if (fail) begin
            s = `EVLRX_DS_FAIL;
        end else if (many_er) begin
            if (par == 2'h2) begin
                s = `EVLRX_DS_ER_P2;
            end else if (par == 2'h1) begin
                s = `EVLRX_DS_ER_P1;
            end else begin
                s = `EVLRX_DS_ER_D2;
            end
        end else if (fix == 2'h2) begin
            s = `EVLRX_DS_D2;
        end else if (fix == 2'h1) begin
            s = (par != 2'h0) ? `EVLRX_DS_D1P1 : `EVLRX_DS_D1;
        end else if (par == 2'h2) begin
            s = `EVLRX_DS_P2;
        end else if (par == 2'h1) begin
            s = `EVLRX_DS_P1;
        end
        return s;
    endfunction

    // Erasure tally of the voted word
    logic [4:0] er_count;
    always_comb begin
        er_count = '0;
        for (int k = 0; k < `EVLRX_WORD_W; k++) begin
            er_count = 5'(er_count + 5'(erased[k]));
        end
    end

    // Held received word and status
    logic [`EVLRX_WORD_W-1:0] word_q, word_d;
    logic [3:0] stat_q, stat_d;
    always_comb begin
        word_d = word_q;
        stat_d = stat_q;
        if (word_load) begin
            word_d = voted;
            stat_d = evlrx_status(parity_errs, data_fixes, uncorrectable,
                                  er_count > 5'h02);
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word_q <= '0;
            stat_q <= `EVLRX_DS_NONE;
        end else begin
            word_q <= word_d;
            stat_q <= stat_d;
        end
    end

    // Read mux; unmapped addresses read zero
    logic [7:0] rdat_d, rdat_q;
    logic rval_q;
    logic [3:0] low_bits;
    genvar j;
    generate
        // Word bit j lands in register bit 4+j
        for (j = 0; j < 4; j++) begin : g_low
            assign low_bits[j] = word_q[j];
        end
    endgenerate
    always_comb begin
        rdat_d = 8'h00;
        case (rd_addr)
            // Snapshot, never the live flags
            `EVLRX_ADDR_EV_PRI: rdat_d = {1'b0, pri_buf_d};
            `EVLRX_ADDR_EV_SEC: rdat_d = sec_buf_q;
            `EVLRX_ADDR_RX_HIGH: rdat_d = word_q[27:20];
            `EVLRX_ADDR_RX_UMID: rdat_d = word_q[19:12];
            `EVLRX_ADDR_RX_LMID: rdat_d = word_q[11:4];
            `EVLRX_ADDR_RX_LOW: rdat_d = {low_bits, stat_q};
            `EVLRX_ADDR_PORT_A: rdat_d = port_a_pins;
            `EVLRX_ADDR_PORT_B: rdat_d = port_b_pins;
            `EVLRX_ADDR_PORT_C: rdat_d = 8'(port_c_pins);
            default: rdat_d = 8'h00;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdat_q <= 8'h00;
            rval_q <= 1'b0;
        end else begin
            rdat_q <= rd_strobe ? rdat_d : rdat_q;
            rval_q <= rd_strobe;
        end
    end
    assign rd_data = rdat_q;
    assign rd_valid = rval_q;

    // Checks
    sequence s_pri_read;
        rd_pri;
    endsequence
    sequence s_sec_close;
        rd_sec && !rd_pri && seq_q == evlrx_pkg::EVLRX_PRI_DONE;
    endsequence

    chk_irq_drop: assert property (
        @(posedge clk) disable iff (!rst_n) s_pri_read |=> !irq_out)
        else $error("irq not dropped on primary read");
    chk_live_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_pri_read |=> pri_q == '0 && sec_q == '0)
        else $error("live flags not cleared");
    chk_pri_snap: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_pri_read |=> rd_data == {1'b0, $past(pri_q) | $past(pri_ev)})
        else $error("primary read not snapshot");
    chk_sec_capture: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_pri_read |=> sec_buf_q == ($past(sec_q) | $past(sec_ev)))
        else $error("secondary snapshot not taken");
    chk_sec_snap: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_sec_close |=> rd_data == $past(sec_buf_q))
        else $error("secondary read not snapshot");
    chk_irq_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        seq_q == evlrx_pkg::EVLRX_PRI_DONE |-> !irq_out)
        else $error("irq active during sequence");
    chk_irq_back: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_sec_close ##0 (|(pri_q & ie_primary)) |=> irq_out)
        else $error("irq not reasserted");
    chk_irq_level: assert property (
        @(posedge clk) disable iff (!rst_n)
        seq_q == evlrx_pkg::EVLRX_IDLE |-> irq_out ==
            (|(pri_q & $past(ie_primary)) ||
             |(sec_q & $past(ie_secondary))))
        else $error("irq does not follow enabled flags");
    chk_ev_latch: assert property (
        @(posedge clk) disable iff (!rst_n)
        ev_timer_zero && !rd_pri |=> pri_q[5])
        else $error("event lost");
    chk_sec_latch: assert property (
        @(posedge clk) disable iff (!rst_n)
        ev_afc_term && !rd_pri |=> sec_q[7])
        else $error("secondary event lost");
    chk_pri_anytime: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_pri_read |=> rd_valid && rd_data[7] == 1'b0)
        else $error("primary read not answered");
    chk_rx_high: assert property (
        @(posedge clk) disable iff (!rst_n)
        rd_strobe && rd_addr == `EVLRX_ADDR_RX_HIGH && !word_load
        |=> rd_data == $past(word_q[27:20]))
        else $error("high byte wrong");
    chk_rx_umid: assert property (
        @(posedge clk) disable iff (!rst_n)
        rd_strobe && rd_addr == `EVLRX_ADDR_RX_UMID
        |=> rd_data == $past(word_q[19:12]))
        else $error("upper mid byte wrong");
    chk_rx_lmid: assert property (
        @(posedge clk) disable iff (!rst_n)
        rd_strobe && rd_addr == `EVLRX_ADDR_RX_LMID
        |=> rd_data == $past(word_q[11:4]))
        else $error("lower mid byte wrong");
    chk_rx_low: assert property (
        @(posedge clk) disable iff (!rst_n)
        rd_strobe && rd_addr == `EVLRX_ADDR_RX_LOW && !word_load
        |=> rd_data[7:4] == $past(word_q[3:0]))
        else $error("low nibble wrong");
    chk_status_fail: assert property (
        @(posedge clk) disable iff (!rst_n)
        word_load && uncorrectable |=> stat_q == `EVLRX_DS_FAIL)
        else $error("uncorrected word not flagged");
    chk_status_erase: assert property (
        @(posedge clk) disable iff (!rst_n)
        word_load && !uncorrectable && er_count > 5'h02
        |=> stat_q[3:2] == 2'b11)
        else $error("erasures not flagged");
    chk_port_live: assert property (
        @(posedge clk) disable iff (!rst_n)
        rd_strobe && rd_addr == `EVLRX_ADDR_PORT_A
        |=> rd_data == $past(port_a_pins))
        else $error("port a not live");
    chk_port_c: assert property (
        @(posedge clk) disable iff (!rst_n)
        rd_strobe && rd_addr == `EVLRX_ADDR_PORT_C
        |=> rd_data == 8'($past(port_c_pins)))
        else $error("port c not live");
endmodule

// File: rtl/evlrx_pkg.sv
// Types shared by the event latch block.
// Assumes nothing of its surroundings.
package evlrx_pkg;
    typedef enum logic [1:0] {
        EVLRX_IDLE = 2'b00,
        EVLRX_PRI_DONE = 2'b01
    } evlrx_seq_t;
endpackage

// File: rtl/evlrx_regs.svh
// Register offsets, field widths and codes of the event latch block.
// Assumes inclusion by bare name from the design files.
`ifndef EVLRX_REGS_SVH
`define EVLRX_REGS_SVH
`define EVLRX_ADDR_EV_PRI 8'h05
`define EVLRX_ADDR_EV_SEC 8'h06
`define EVLRX_ADDR_RX_HIGH 8'h10
`define EVLRX_ADDR_RX_UMID 8'h11
`define EVLRX_ADDR_RX_LMID 8'h12
`define EVLRX_ADDR_RX_LOW 8'h13
`define EVLRX_ADDR_PORT_A 8'h16
`define EVLRX_ADDR_PORT_B 8'h18
`define EVLRX_ADDR_PORT_C 8'h1A
`define EVLRX_PRI_W 7
`define EVLRX_SEC_W 8
`define EVLRX_PORT_C_W 4
`define EVLRX_WORD_W 28
`define EVLRX_DS_NONE 4'h0
`define EVLRX_DS_P1 4'h1
`define EVLRX_DS_P2 4'h2
`define EVLRX_DS_D1 4'h4
`define EVLRX_DS_D1P1 4'h5
`define EVLRX_DS_D2 4'h8
`define EVLRX_DS_ER_D2 4'hC
`define EVLRX_DS_ER_P1 4'hD
`define EVLRX_DS_ER_P2 4'hE
`define EVLRX_DS_FAIL 4'hF
`endif

// File: rtl/evlrx_vote.sv
// Per-bit repeat vote of the received word, with erasure marks.
// Assumes one-hot repeat strobes; counts stay small.
`timescale 1ns/100ps
`include "evlrx_regs.svh"
module evlrx_vote #(
    parameter int WIDTH = `EVLRX_WORD_W,
    parameter int CW = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Repeats
    input wire logic clear,
    input wire logic rep_valid,
    input wire logic [WIDTH-1:0] rep_bits,
    // Result
    output logic [WIDTH-1:0] voted,
    output logic [WIDTH-1:0] erased
);
    // Refuse shapes the counters cannot serve
    if (WIDTH < 1 || CW < 2) begin : g_bad_param
        $error("evlrx_vote: bad parameters");
    end
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic [CW-1:0] ones_q, ones_d, zeros_q, zeros_d;
            always_comb begin
                ones_d = ones_q;
                zeros_d = zeros_q;
                if (clear) begin
                    ones_d = '0;
                    zeros_d = '0;
                end else if (rep_valid) begin
                    if (rep_bits[i]) begin
                        ones_d = CW'(ones_q + 1'b1);
                    end else begin
                        zeros_d = CW'(zeros_q + 1'b1);
                    end
                end
            end
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    ones_q <= '0;
                    zeros_q <= '0;
                end else begin
                    ones_q <= ones_d;
                    zeros_q <= zeros_d;
                end
            end
            assign voted[i] = ones_q > zeros_q;
            // Tie with at least one repeat seen marks an erasure
            assign erased[i] = (ones_q == zeros_q) && (ones_q != '0);
        end
    endgenerate
endmodule

// File: testbench/evlrx_mcu_model.sv
// Controller model that reads the event latch block registers.
// Assumes one-cycle read strobes, answered by the rd_valid pulse.
`timescale 1ns/100ps
module evlrx_mcu_model (
    // Clock
    input wire logic clk,
    // Read port
    output logic rd_strobe,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    initial begin
        rd_strobe = 1'b0;
        rd_addr = 8'h00;
    end
    // Callers read primary first, then secondary, except the secondary read right after the mid-sequence reset
    task automatic read_reg(input logic [7:0] a, input int gap,
                            output logic [7:0] d, output bit ok);
        ok = 1'b0;
        d = 8'h00;
        repeat (gap) @(posedge clk);
        @(posedge clk);
        #1 rd_strobe = 1'b1;
        rd_addr = a;
        @(posedge clk);
        #1 rd_strobe = 1'b0;
        // Released address shows a changed value, not the old one
        rd_addr = ~a;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (rd_valid === 1'b1) begin
                ok = 1'b1;
                d = rd_data;
            end else begin
                @(posedge clk);
                #1;
            end
        end
    endtask
endmodule

// File: testbench/tb_event_latch_and_rx_readout.sv
// Self-checking bench of the event latch and received word readout.
// Assumes the controller model drives the read port.
`timescale 1ns/100ps
module tb_event_latch_and_rx_readout;
    typedef struct packed {
        logic [14:0] ev;
        logic [6:0] pri;
        logic [7:0] sec;
    } evlrx_ev_row_t;
    typedef struct packed {
        logic [1:0] p;
        logic [1:0] f;
        logic u;
        logic e;
        logic [3:0] s;
    } evlrx_dec_row_t;
    localparam logic [27:0] WORD = 28'hA5C3E96;
    logic clk = 1'b0;
    logic rst_n, rd_strobe, rd_valid, irq_out;
    logic rep_clear, rep_valid, word_load, unc;
    logic [7:0] rd_addr, rd_data, pa, pb, ie_s;
    logic [6:0] ie_p;
    logic [14:0] ev;
    logic [27:0] rep_bits;
    logic [1:0] par, fix;
    logic [3:0] pc;
    int error_cnt = 0;
    int check_count = 0;
    evlrx_ev_row_t rows [16] = '{
        '{15'h0001, 7'h01, 8'h00}, '{15'h0002, 7'h02, 8'h00},
        '{15'h0004, 7'h04, 8'h00}, '{15'h0008, 7'h08, 8'h00},
        '{15'h0010, 7'h10, 8'h00}, '{15'h0020, 7'h20, 8'h00},
        '{15'h0040, 7'h40, 8'h00}, '{15'h0080, 7'h00, 8'h01},
        '{15'h0100, 7'h00, 8'h02}, '{15'h0200, 7'h00, 8'h04},
        '{15'h0400, 7'h00, 8'h08}, '{15'h0800, 7'h00, 8'h10},
        '{15'h1000, 7'h00, 8'h20}, '{15'h2000, 7'h00, 8'h40},
        '{15'h4000, 7'h00, 8'h80}, '{15'h7FFF, 7'h7F, 8'hFF}};
    evlrx_dec_row_t drows [10] = '{
        '{2'h0, 2'h0, 1'b0, 1'b0, 4'h0}, '{2'h1, 2'h0, 1'b0, 1'b0, 4'h1},
        '{2'h2, 2'h0, 1'b0, 1'b0, 4'h2}, '{2'h0, 2'h1, 1'b0, 1'b0, 4'h4},
        '{2'h1, 2'h1, 1'b0, 1'b0, 4'h5}, '{2'h0, 2'h2, 1'b0, 1'b0, 4'h8},
        '{2'h0, 2'h2, 1'b0, 1'b1, 4'hC}, '{2'h1, 2'h1, 1'b0, 1'b1, 4'hD},
        '{2'h2, 2'h0, 1'b0, 1'b1, 4'hE}, '{2'h0, 2'h0, 1'b1, 1'b0, 4'hF}};

    always #5 clk = ~clk;

    evlrx_core evlrx_core_inst (
        .clk(clk), .rst_n(rst_n), .rd_strobe(rd_strobe),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .ev_rx_avail(ev[0]), .ev_tx_buf_avail(ev[1]),
        .ev_arb_fail(ev[2]), .ev_tx_done(ev[3]),
        .ev_busy_change(ev[4]), .ev_timer_zero(ev[5]),
        .ev_sat_change(ev[6]), .ev_data_change(ev[7]),
        .ev_dotting(ev[8]), .ev_fvc_sync(ev[9]), .ev_focc_sync(ev[10]),
        .ev_idle_ps(ev[11]), .ev_narrowband_error_tally(ev[12]),
        .ev_gpio_group_three(ev[13]), .ev_afc_term(ev[14]),
        .ie_primary(ie_p), .ie_secondary(ie_s), .rep_clear(rep_clear),
        .rep_valid(rep_valid), .rep_bits(rep_bits),
        .word_load(word_load), .parity_errs(par), .data_fixes(fix),
        .uncorrectable(unc), .port_a_pins(pa), .port_b_pins(pb),
        .port_c_pins(pc), .irq_out(irq_out));

    evlrx_mcu_model evlrx_mcu_model_inst (
        .clk(clk), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid));

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input int g);
        logic [7:0] d;
        bit ok;
        evlrx_mcu_model_inst.read_reg(a, g, d, ok);
        // A missing answer must not pass as a match
        if (!ok) d = ~e;
        chk(d, e);
    endtask
    task automatic pulse(input logic [14:0] v);
        @(posedge clk);
        #1 ev = v;
        @(posedge clk);
        #1 ev = 15'h0000;
        @(posedge clk);
        #1;
    endtask
    task automatic load(input evlrx_dec_row_t r);
        @(posedge clk);
        #1 rep_clear = 1'b1;
        @(posedge clk);
        #1 rep_clear = 1'b0;
        rep_valid = 1'b1;
        rep_bits = WORD;
        // A second, disagreeing repeat ties three bits
        @(posedge clk);
        #1 rep_valid = r.e;
        rep_bits = WORD ^ 28'hE000000;
        @(posedge clk);
        #1 rep_valid = 1'b0;
        par = r.p;
        fix = r.f;
        unc = r.u;
        @(posedge clk);
        #1 word_load = 1'b1;
        @(posedge clk);
        #1 word_load = 1'b0;
    endtask
    task automatic close_out();
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #200us;
        error_cnt++;
        close_out();
    end

    initial begin
        {rst_n, rep_clear, rep_valid, word_load, unc} = 5'h00;
        {ev, rep_bits, par, fix, pa, pb, pc} = '0;
        ie_p = 7'h7F;
        ie_s = 8'hFF;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        chk({7'h00, irq_out}, 8'h00);
        chk(rd_data, 8'h00);
        for (int i = 0; i < 16; i++) begin
            pulse(rows[i].ev);
            chk({7'h00, irq_out}, 8'h01);
            rd(8'h05, {1'b0, rows[i].pri}, i % 3);
            chk({7'h00, irq_out}, 8'h00);
            rd(8'h06, rows[i].sec, 0);
        end
        // Flags latch with enables off; no interrupt is needed to read
        {ie_p, ie_s} = 15'h0000;
        pulse(15'h0004);
        chk({7'h00, irq_out}, 8'h00);
        rd(8'h05, 8'h04, 0);
        rd(8'h06, 8'h00, 0);
        // Events arriving between the two reads stay queued
        {ie_p, ie_s} = 15'h7FFF;
        pulse(15'h0080);
        rd(8'h05, 8'h00, 0);
        pulse(15'h0101);
        chk({7'h00, irq_out}, 8'h00);
        rd(8'h06, 8'h01, 2);
        chk({7'h00, irq_out}, 8'h01);
        rd(8'h05, 8'h01, 0);
        rd(8'h06, 8'h02, 0);
        chk({7'h00, irq_out}, 8'h00);
        for (int i = 0; i < 10; i++) begin
            load(drows[i]);
            rd(8'h13, {4'h6, drows[i].s}, 0);
            if (i == 0) begin
                rd(8'h10, 8'hA5, 0);
                rd(8'h11, 8'hC3, 0);
                rd(8'h12, 8'hE9, 0);
            end
        end
        pa = 8'h5A;
        pb = 8'hC3;
        pc = 4'h9;
        rd(8'h16, 8'h5A, 0);
        rd(8'h18, 8'hC3, 0);
        rd(8'h1A, 8'h09, 1);
        pa = 8'hA5;
        rd(8'h16, 8'hA5, 0);
        rd(8'h07, 8'h00, 0);
        rd(8'h1B, 8'h00, 0);
        // Reset in mid-sequence drops queued flags and the interrupt
        pulse(15'h7FFF);
        rd(8'h05, 8'h7F, 0);
        pulse(15'h7FFF);
        chk({7'h00, irq_out}, 8'h00);
        @(posedge clk);
        #1 rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        chk({7'h00, irq_out}, 8'h00);
        chk(rd_data, 8'h00);
        rd(8'h06, 8'h00, 0);
        rd(8'h05, 8'h00, 0);
        rd(8'h06, 8'h00, 0);
        chk({7'h00, irq_out}, 8'h00);
        close_out();
    end
endmodule
